// ===== src/bit_sync.sv
// Two-stage level synchroniser.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter logic reset_level = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic d_in,
  output logic q_out
);
  logic stage1_reg;
  logic stage2_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage1_reg <= reset_level;
      stage2_reg <= reset_level;
    end else begin
      stage1_reg <= d_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign q_out = stage2_reg;
endmodule : bit_sync
`default_nettype wire

// ===== src/host_port_select.sv
// Top of the dedicated control and status pins: port mux, restart, recovery
// strap, time pulse, interrupt input, correction status and antenna enable.
// Assumes pin inputs are asynchronous levels and port side signals are internal.
`timescale 1ns/100ps
`default_nettype none
module host_port_select #(
  parameter int unsigned restart_cycles = pin_ctrl_pkg::restart_min_cycles,
  parameter int unsigned blink_cycles = pin_ctrl_pkg::blink_half_cycles
) (
  input wire logic clk_in,
  input wire logic reset_in,
  // Straps and restart
  input wire logic port_select_in,
  input wire logic recovery_boot_n_in,
  input wire logic restart_n_in,
  // Shared pins
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe_out,
  input wire logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe_out,
  input wire logic pin_c_in,
  output logic pin_c_out,
  output logic pin_c_oe_out,
  input wire logic pin_d_in,
  output logic pin_d_out,
  output logic pin_d_oe_out,
  // Peripheral serial port side
  input wire logic periph_serial_out_in,
  output logic periph_serial_in_out,
  output logic periph_select_n_out,
  output logic periph_clock_out,
  output logic periph_enable_out,
  // Async port and two-wire side
  input wire logic async_tx_in,
  output logic async_rx_out,
  output logic async_enable_out,
  input wire logic twowire_data_drive_low_in,
  input wire logic twowire_clock_drive_low_in,
  output logic twowire_data_out,
  output logic twowire_clock_out,
  // USB gating
  output logic usb_enable_out,
  // Boot and restart
  output logic recovery_mode_out,
  output logic positioning_enable_out,
  output logic cold_start_out,
  output logic erase_retained_out,
  // Time pulse
  input wire logic time_pulse_in,
  output logic precise_second_marker_out,
  // Interrupt input
  input wire logic ext_interrupt_in,
  input wire logic ext_interrupt_enable_in,
  input wire logic freq_aid_enable_in,
  input wire logic wake_on_interrupt_in,
  input wire logic backup_mode_in,
  output logic [pin_ctrl_pkg::cal_width-1:0] ref_period_out,
  output logic ref_period_valid_out,
  output logic wake_out,
  // Correction status
  input wire logic [1:0] carrier_solution_field_in,
  input wire logic correction_supported_in,
  input wire logic correction_used_in,
  output logic carrier_fix_indicator_out,
  // Antenna
  input wire logic software_backup_in,
  output logic antenna_power_enable_out
);
  import pin_ctrl_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic sel_sync;
  logic boot_n_sync;
  logic restart_n_sync;
  logic extint_sync;
  bit_sync #(.reset_level(1'b0)) u_sel_sync (.clk_in(clk_in), .reset_in(reset_in),
    .d_in(port_select_in), .q_out(sel_sync));
  bit_sync #(.reset_level(1'b1)) u_boot_sync (.clk_in(clk_in), .reset_in(reset_in),
    .d_in(recovery_boot_n_in), .q_out(boot_n_sync));
  bit_sync #(.reset_level(1'b1)) u_restart_sync (.clk_in(clk_in), .reset_in(reset_in),
    .d_in(restart_n_in), .q_out(restart_n_sync));
  bit_sync #(.reset_level(1'b0)) u_extint_sync (.clk_in(clk_in), .reset_in(reset_in),
    .d_in(ext_interrupt_in), .q_out(extint_sync));

  // ------------------------------------------------------------
  // Strap capture after reset release
  // ------------------------------------------------------------
  boot_state_t boot_reg;
  boot_state_t boot_next;
  logic sel_reg;
  logic sel_next;
  // Two-cycle settle before straps are trusted
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  always_comb begin
    settle_next = (settle_reg == strap_settle_count) ? settle_reg : settle_reg + 2'h1;
  end
  always_comb begin
    boot_next = boot_reg;
    sel_next = sel_reg;
    if (settle_reg == strap_settle_count) begin
      case (boot_reg)
        boot_wait: begin
          sel_next = sel_sync;
          boot_next = boot_n_sync ? boot_normal : boot_recovery;
        end
        boot_normal: begin
          boot_next = boot_normal;
        end
        default: begin
          boot_next = boot_recovery;
        end
      endcase
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      boot_reg <= boot_wait;
      sel_reg <= 1'b0;
      settle_reg <= 2'h0;
    end else begin
      settle_reg <= settle_next;
      boot_reg <= boot_next;
      sel_reg <= sel_next;
    end
  end
  logic booted;
  assign booted = (boot_reg != boot_wait);
  assign recovery_mode_out = (boot_reg == boot_recovery);
  assign positioning_enable_out = (boot_reg == boot_normal);
  assign usb_enable_out = (boot_reg == boot_normal);

  // ------------------------------------------------------------
  // Shared pin routing
  // ------------------------------------------------------------
  logic periph_mode;
  assign periph_mode = booted && !sel_reg;
  assign periph_enable_out = periph_mode;
  assign async_enable_out = booted && sel_reg;
  // Pin A: serial data out or async transmit
  assign pin_a_out = periph_mode ? periph_serial_out_in : async_tx_in;
  assign pin_a_oe_out = booted;
  // Pin B: serial data in or async receive, input only
  assign pin_b_out = 1'b0;
  assign pin_b_oe_out = 1'b0;
  assign periph_serial_in_out = periph_mode ? pin_b_in : 1'b1;
  assign async_rx_out = (booted && sel_reg) ? pin_b_in : 1'b1;
  // Pins C and D: select and clock, or open-drain two-wire data and clock
  assign pin_c_out = 1'b0;
  assign pin_c_oe_out = booted && sel_reg && twowire_data_drive_low_in;
  assign pin_d_out = 1'b0;
  assign pin_d_oe_out = booted && sel_reg && twowire_clock_drive_low_in;
  assign periph_select_n_out = periph_mode ? pin_c_in : 1'b1;
  assign periph_clock_out = periph_mode ? pin_d_in : 1'b0;
  assign twowire_data_out = (booted && sel_reg) ? pin_c_in : 1'b1;
  assign twowire_clock_out = (booted && sel_reg) ? pin_d_in : 1'b1;

  // ------------------------------------------------------------
  // Cold restart from long low pulse
  // ------------------------------------------------------------
  logic restart_fire;
  low_pulse_timer #(.limit(restart_cycles)) u_restart_timer (.clk_in(clk_in),
    .reset_in(reset_in), .level_n_in(restart_n_sync), .fire_out(restart_fire));
  assign cold_start_out = restart_fire;
  assign erase_retained_out = restart_fire;

  // ------------------------------------------------------------
  // Time pulse output
  // ------------------------------------------------------------
  logic marker_reg;
  logic marker_next;
  always_comb begin
    marker_next = time_pulse_in;
  end

  // ------------------------------------------------------------
  // Interrupt input: edge period and wake
  // ------------------------------------------------------------
  logic extint_prev_reg;
  logic [cal_width-1:0] period_cnt_reg;
  logic [cal_width-1:0] period_cnt_next;
  logic [cal_width-1:0] period_reg;
  logic [cal_width-1:0] period_next;
  logic period_valid_reg;
  logic period_valid_next;
  logic seen_edge_reg;
  logic seen_edge_next;
  logic wake_reg;
  logic wake_next;
  logic rise;
  assign rise = extint_sync && !extint_prev_reg;
  always_comb begin
    period_cnt_next = period_cnt_reg + cal_width'(1);
    period_next = period_reg;
    period_valid_next = 1'b0;
    seen_edge_next = seen_edge_reg;
    wake_next = 1'b0;
    if (!ext_interrupt_enable_in) begin
      period_cnt_next = '0;
      seen_edge_next = 1'b0;
    end else begin
      if (rise && freq_aid_enable_in) begin
        period_cnt_next = cal_width'(1);
        seen_edge_next = 1'b1;
        if (seen_edge_reg) begin
          period_next = period_cnt_reg;
          period_valid_next = 1'b1;
        end
      end
      wake_next = backup_mode_in && wake_on_interrupt_in &&
        (extint_sync != extint_prev_reg);
    end
  end

  // ------------------------------------------------------------
  // Correction status indicator
  // ------------------------------------------------------------
  logic [count_width-1:0] blink_cnt_reg;
  logic [count_width-1:0] blink_cnt_next;
  logic status_reg;
  logic status_next;
  logic corr_valid;
  assign corr_valid = correction_supported_in && correction_used_in;
  always_comb begin
    blink_cnt_next = '0;
    status_next = status_reset_level;
    if (carrier_solution_field_in == carrier_fixed) begin
      status_next = 1'b0;
    end else if (corr_valid && carrier_solution_field_in == carrier_float) begin
      status_next = status_reg;
      blink_cnt_next = blink_cnt_reg + count_width'(1);
      if (blink_cnt_reg >= count_width'(blink_cycles - 1)) begin
        blink_cnt_next = '0;
        status_next = !status_reg;
      end
    end else begin
      status_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Antenna power enable and output registers
  // ------------------------------------------------------------
  logic antenna_reg;
  logic antenna_next;
  always_comb begin
    antenna_next = !software_backup_in;
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      marker_reg <= 1'b0;
      extint_prev_reg <= 1'b0;
      period_cnt_reg <= '0;
      period_reg <= '0;
      period_valid_reg <= 1'b0;
      seen_edge_reg <= 1'b0;
      wake_reg <= 1'b0;
      blink_cnt_reg <= '0;
      status_reg <= status_reset_level;
      antenna_reg <= antenna_reset_level;
    end else begin
      marker_reg <= marker_next;
      extint_prev_reg <= extint_sync;
      period_cnt_reg <= period_cnt_next;
      period_reg <= period_next;
      period_valid_reg <= period_valid_next;
      seen_edge_reg <= seen_edge_next;
      wake_reg <= wake_next;
      blink_cnt_reg <= blink_cnt_next;
      status_reg <= status_next;
      antenna_reg <= antenna_next;
    end
  end
  assign precise_second_marker_out = marker_reg;
  assign ref_period_out = period_reg;
  assign ref_period_valid_out = period_valid_reg;
  assign wake_out = wake_reg;
  assign carrier_fix_indicator_out = status_reg;
  assign antenna_power_enable_out = antenna_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_fixed;
    carrier_solution_field_in == carrier_fixed;
  endsequence
  sequence s_none;
    carrier_solution_field_in == carrier_none;
  endsequence
  property p_periph_only_low;
    @(posedge clk_in) disable iff (reset_in) periph_enable_out |-> !sel_reg;
  endproperty
  a_periph_only_low: assert property (p_periph_only_low) else $error("periph on with strap high");
  property p_async_map;
    @(posedge clk_in) disable iff (reset_in)
      (booted && sel_reg) |-> (pin_a_out == async_tx_in && twowire_data_out == pin_c_in);
  endproperty
  a_async_map: assert property (p_async_map) else $error("async mapping wrong");
  property p_restart_fire;
    @(posedge clk_in) disable iff (reset_in)
      cold_start_out |-> $past(restart_n_sync) == 1'b0;
  endproperty
  a_restart_fire: assert property (p_restart_fire) else $error("cold start without low restart");
  property p_erase_with_cold;
    @(posedge clk_in) disable iff (reset_in) cold_start_out == erase_retained_out;
  endproperty
  a_erase_with_cold: assert property (p_erase_with_cold) else $error("erase not with cold start");
  property p_recovery_no_usb;
    @(posedge clk_in) disable iff (reset_in)
      recovery_mode_out |-> (!usb_enable_out && !positioning_enable_out);
  endproperty
  a_recovery_no_usb: assert property (p_recovery_no_usb) else $error("usb on in recovery");
  property p_extint_off;
    @(posedge clk_in) disable iff (reset_in)
      !ext_interrupt_enable_in |=> (!wake_out && !ref_period_valid_out);
  endproperty
  a_extint_off: assert property (p_extint_off) else $error("interrupt active while off");
  property p_fixed_low;
    @(posedge clk_in) disable iff (reset_in) s_fixed |=> !carrier_fix_indicator_out;
  endproperty
  a_fixed_low: assert property (p_fixed_low) else $error("status not low on fix");
  property p_none_high;
    @(posedge clk_in) disable iff (reset_in) s_none |=> carrier_fix_indicator_out;
  endproperty
  a_none_high: assert property (p_none_high) else $error("status not high with no solution");
  property p_antenna_off;
    @(posedge clk_in) disable iff (reset_in) software_backup_in |=> !antenna_power_enable_out;
  endproperty
  a_antenna_off: assert property (p_antenna_off) else $error("antenna on in backup");
endmodule : host_port_select
`default_nettype wire

// ===== src/low_pulse_timer.sv
// Counts how long a synchronised level has been low; fires once at the limit.
// Assumes the input is already synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module low_pulse_timer #(
  parameter int unsigned limit = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic level_n_in,
  output logic fire_out
);
  import pin_ctrl_pkg::*;
  logic [count_width-1:0] count_reg;
  logic [count_width-1:0] count_next;
  logic fire_reg;
  logic fire_next;
  always_comb begin
    count_next = count_reg;
    fire_next = 1'b0;
    if (level_n_in) begin
      count_next = '0;
    end else if (count_reg < count_width'(limit)) begin
      count_next = count_reg + count_width'(1);
      fire_next = (count_next == count_width'(limit));
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      fire_reg <= fire_next;
    end
  end
  assign fire_out = fire_reg;
endmodule : low_pulse_timer
`default_nettype wire

// ===== src/pin_ctrl_pkg.sv
// Constants and types for the receiver's dedicated control and status pins.
// Assumes a single 200 MHz clock and an asynchronous active-high reset.
// Functional notes
// - Shared pins carry the peripheral serial port only while the select strap is low.
// - Strap high maps shared pins to async transmit, receive, two-wire data and clock.
// - Restart pin is input only; undriven it reads high through a pull-up.
// - Restart held low at least 100 ms triggers a cold start.
// - Pin-triggered cold restart erases all retained receiver information.
// - Recovery strap sampled at power-up; low enters recovery mode, positioning off.
// - Recovery mode blocks USB; async, two-wire and peripheral ports still work.
// - A dedicated output carries the periodic time pulse configured elsewhere.
// - Interrupt input function is off after reset until configured.
// - Interrupt input edges may serve as a frequency reference for clock calibration.
// - When configured, interrupt input activity wakes the device from backup.
// - Status pin blinks while corrections are used with a float carrier-phase solution.
// - Status pin held low while a fixed carrier-phase solution holds.
// - Status pin held high while no carrier-phase solution exists.
// - Only supported and used correction messages count as valid.
// - Antenna power enable is deasserted during software backup mode.
package pin_ctrl_pkg;
  localparam int unsigned clk_freq_hz = 200_000_000;
  localparam int unsigned restart_min_ms = 100;
  localparam int unsigned restart_min_cycles = restart_min_ms * (clk_freq_hz / 1000);
  localparam int unsigned blink_half_ms = 250;
  localparam int unsigned blink_half_cycles = blink_half_ms * (clk_freq_hz / 1000);
  localparam int unsigned count_width = 32;
  localparam int unsigned sync_stages = 2;
  localparam logic [1:0] strap_settle_count = 2'h2;
  localparam int unsigned cal_width = 32;
  localparam logic [1:0] carrier_none = 2'h0;
  localparam logic [1:0] carrier_float = 2'h1;
  localparam logic [1:0] carrier_fixed = 2'h2;
  localparam logic status_reset_level = 1'b1;
  localparam logic antenna_reset_level = 1'b1;
  typedef enum logic [1:0] {boot_wait, boot_normal, boot_recovery} boot_state_t;
endpackage : pin_ctrl_pkg

// ===== tb/host_pins_model.sv
// Host side of the dedicated pins: restart line, shared pins and pull-ups.
// Assumes the host drives levels; the device drives pins through out and oe.
`timescale 1ns/100ps
`default_nettype none
module host_pins_model (
  input wire logic restart_low_in,
  input wire logic host_b_in,
  input wire logic host_c_in,
  input wire logic host_d_in,
  input wire logic dev_a_in,
  input wire logic dev_a_oe_in,
  input wire logic dev_c_in,
  input wire logic dev_c_oe_in,
  input wire logic dev_d_in,
  input wire logic dev_d_oe_in,
  output logic restart_n_out,
  output logic wire_a_out,
  output logic wire_b_out,
  output logic wire_c_out,
  output logic wire_d_out
);
  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // Released restart line floats high through the pull-up
  assign restart_n_out = ~restart_low_in;
  // Undriven pin shows the inverse of the device value
  assign wire_a_out = dev_a_oe_in ? dev_a_in : ~dev_a_in;
  assign wire_b_out = host_b_in;
  // Wired-and with pull-up: either side may pull low
  assign wire_c_out = host_c_in & ~(dev_c_oe_in & ~dev_c_in);
  assign wire_d_out = host_d_in & ~(dev_d_oe_in & ~dev_d_in);
endmodule : host_pins_model
`default_nettype wire

// ===== tb/test_host_port_select_and_status_pins.sv
// Self-checking testbench for the dedicated control and status pins.
// Assumes the design package, modules and the host pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_host_port_select_and_status_pins;
  import pin_ctrl_pkg::*;
  // Scaled training bit time and pause keep the run short
  localparam int train_bit_cycles = 4;
  localparam int train_pause_cycles = 8;
  typedef struct packed {logic s; logic r; logic [4:0] pat; logic [15:0] exp;} row_t;
  logic clk, rst, sel, rec_n, rlow, hb, hc, hd, src, dl, tp, ext, ext_en, faid, wk, bkp;
  logic [1:0] field;
  logic csup, cused, swb, restart_n, wa, wb, wc, wd;
  logic a_out, a_oe, b_out, b_oe, c_out, c_oe, d_out, d_oe, psi, seln, pclk, pen;
  logic arx, aen, twd, twc, usb, recov, posit, cold, erase, marker, rpv, wake, ind, ant;
  logic [31:0] per;
  logic [31:0] last_per = '0;
  logic [15:0] seen;
  logic ind_prev = 1'b1;
  int fail_count, checks, cold_n, erase_n, valid_n, wake_n, tog_n, c0, e0, v0, w0, t0;
  row_t rows [5] = '{'{1'b0, 1'b1, 5'h1a, 16'hae5e}, '{1'b0, 1'b0, 5'h05, 16'h922e},
    '{1'b1, 1'b1, 5'h16, 16'h6a66}, '{1'b1, 1'b0, 5'h0f, 16'h57e8},
    '{1'b1, 1'b1, 5'h0a, 16'h6e6a}};
  assign seen = {pen, aen, usb, recov, posit, a_out, a_oe, c_oe, d_oe, psi, seln, pclk,
    arx, twd, twc, b_oe};

  host_port_select #(.restart_cycles(10), .blink_cycles(4)) dut (.clk_in(clk),
    .reset_in(rst), .port_select_in(sel), .recovery_boot_n_in(rec_n),
    .restart_n_in(restart_n), .pin_a_in(wa), .pin_a_out(a_out), .pin_a_oe_out(a_oe),
    .pin_b_in(wb), .pin_b_out(b_out), .pin_b_oe_out(b_oe), .pin_c_in(wc),
    .pin_c_out(c_out), .pin_c_oe_out(c_oe), .pin_d_in(wd), .pin_d_out(d_out),
    .pin_d_oe_out(d_oe), .periph_serial_out_in(src), .periph_serial_in_out(psi),
    .periph_select_n_out(seln), .periph_clock_out(pclk), .periph_enable_out(pen),
    .async_tx_in(~src), .async_rx_out(arx), .async_enable_out(aen),
    .twowire_data_drive_low_in(dl), .twowire_clock_drive_low_in(dl),
    .twowire_data_out(twd), .twowire_clock_out(twc), .usb_enable_out(usb),
    .recovery_mode_out(recov), .positioning_enable_out(posit), .cold_start_out(cold),
    .erase_retained_out(erase), .time_pulse_in(tp), .precise_second_marker_out(marker),
    .ext_interrupt_in(ext), .ext_interrupt_enable_in(ext_en), .freq_aid_enable_in(faid),
    .wake_on_interrupt_in(wk), .backup_mode_in(bkp), .ref_period_out(per),
    .ref_period_valid_out(rpv), .wake_out(wake), .carrier_solution_field_in(field),
    .correction_supported_in(csup), .correction_used_in(cused),
    .carrier_fix_indicator_out(ind), .software_backup_in(swb),
    .antenna_power_enable_out(ant));

  host_pins_model host (.restart_low_in(rlow), .host_b_in(hb), .host_c_in(hc),
    .host_d_in(hd), .dev_a_in(a_out), .dev_a_oe_in(a_oe), .dev_c_in(c_out),
    .dev_c_oe_in(c_oe), .dev_d_in(d_out), .dev_d_oe_in(d_oe), .restart_n_out(restart_n),
    .wire_a_out(wa), .wire_b_out(wb), .wire_c_out(wc), .wire_d_out(wd));

  // ---------------------------------------------------------------
  // Clock and event counters
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cold === 1'b1) cold_n++;
    if (erase === 1'b1) erase_n++;
    if (rpv === 1'b1) valid_n++;
    if (rpv === 1'b1) last_per = per;
    if (wake === 1'b1) wake_n++;
    if (ind !== ind_prev) tog_n++;
    ind_prev = ind;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic do_reset(input logic s, input logic r);
    int n;
    @(posedge clk);
    rst <= 1'b1;
    sel <= s;
    rec_n <= r;
    cyc(3);
    #1 chk("reset levels", {marker, ind, ant, cold, erase, usb, a_oe, pen, aen, wake, rpv},
      11'h300);
    cyc(1);
    rst <= 1'b0;
    n = 0;
    while (a_oe !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      fail_count++;
      end_of_test();
    end
    cyc(2);
  endtask : do_reset

  task automatic ext_pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      ext <= 1'b1;
      cyc(hi);
      ext <= 1'b0;
      cyc(lo);
    end
    cyc(6);
  endtask : ext_pulses

  task automatic train_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hb <= frame[i];
      cyc(1);
      #1 chk("async rx bit", arx, frame[i]);
      cyc(train_bit_cycles - 1);
    end
  endtask : train_byte

  task automatic snap;
    c0 = cold_n;
    e0 = erase_n;
    v0 = valid_n;
    w0 = wake_n;
    t0 = tog_n;
  endtask : snap

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, sel, rec_n, rlow, hb, hc, hd, src, dl, tp, ext, ext_en, faid, wk, bkp} = 15'h5700;
    {field, csup, cused, swb} = 5'h00;
    fail_count = 0;
    checks = 0;
    cyc(4);
    rst <= 1'b0;
    foreach (rows[i]) begin
      do_reset(rows[i].s, rows[i].r);
      {src, hb, hc, hd, dl} <= rows[i].pat;
      cyc(2);
      #1 chk("port map", seen, rows[i].exp);
      chk("idle drive", {b_out, c_out, d_out}, 3'h0);
    end
    {src, hb, hc, hd, dl} <= 5'h1e;
    do_reset(1'b0, 1'b1);
    sel <= 1'b1;
    cyc(6);
    #1 chk("strap kept", {pen, aen, usb}, 3'h5);
    snap();
    rlow <= 1'b1;
    cyc(8);
    rlow <= 1'b0;
    cyc(20);
    chk("short restart", cold_n - c0, 0);
    rlow <= 1'b1;
    cyc(30);
    rlow <= 1'b0;
    cyc(5);
    chk("cold start", cold_n - c0, 1);
    chk("erase", erase_n - e0, 1);
    tp <= 1'b1;
    cyc(1);
    tp <= 1'b0;
    #1 chk("marker high", marker, 1);
    cyc(1);
    #1 chk("marker low", marker, 0);
    field <= carrier_fixed;
    cyc(3);
    #1 chk("fixed level", ind, 0);
    field <= carrier_none;
    {csup, cused} <= 2'h3;
    cyc(3);
    #1 chk("none level", ind, 1);
    for (int k = 0; k < 3; k++) begin
      field <= carrier_float;
      {csup, cused} <= k[1:0] + 2'h1;
      cyc(3);
      snap();
      cyc(24);
      chk("blink", (tog_n - t0 >= 5) && (tog_n - t0 <= 7), k == 2);
      chk("steady", (tog_n - t0 == 0), k != 2);
    end
    swb <= 1'b1;
    cyc(2);
    #1 chk("antenna off", ant, 0);
    swb <= 1'b0;
    cyc(2);
    #1 chk("antenna on", ant, 1);
    faid <= 1'b1;
    snap();
    ext_pulses(3, 2, 8);
    chk("disabled ref", valid_n - v0, 0);
    ext_en <= 1'b1;
    cyc(2);
    snap();
    ext_pulses(4, 2, 8);
    chk("ref count", valid_n - v0, 3);
    chk("ref period", last_per, 10);
    {faid, wk, bkp} <= 3'h3;
    cyc(2);
    snap();
    ext_pulses(2, 3, 3);
    chk("wake", wake_n - w0, 4);
    bkp <= 1'b0;
    cyc(2);
    snap();
    ext_pulses(2, 3, 3);
    chk("no wake", wake_n - w0, 0);
    do_reset(1'b1, 1'b0);
    train_byte(8'h55);
    train_byte(8'h55);
    cyc(train_pause_cycles);
    train_byte(8'ha5);
    #1 chk("recovery async", {recov, usb, aen, pen}, 4'ha);
    end_of_test();
  end
endmodule : test_host_port_select_and_status_pins
`default_nettype wire
